// file: sdr_pkg.sv
// constants, types and register map of the screed drying sequencer
`default_nettype none
package sdr_pkg;
  // time base: each time kept in its own unit, cycle count derived
  localparam longint CLK_PERIOD_NS = 10;
  localparam longint SEC_TIME_NS = 1000000000;
  localparam longint CYC_PER_SEC = SEC_TIME_NS / CLK_PERIOD_NS;
  localparam logic [5:0] SEC_PER_MIN = 6'h3C;
  localparam logic [5:0] MIN_PER_HOUR = 6'h3C;
  localparam logic [7:0] HOUR_PER_DAY = 8'h18;
  localparam logic [5:0] LAST_HOUR = 6'h17;

  // register byte offsets
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_TEMP = 12'h004;
  localparam logic [11:0] ADDR_TIME = 12'h008;
  localparam logic [11:0] ADDR_CIRC = 12'h00C;
  localparam logic [11:0] ADDR_STAT = 12'h010;
  localparam logic [11:0] ADDR_REMAIN = 12'h014;
  localparam logic [11:0] ADDR_SETT = 12'h018;

  // field positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_CANCEL_BIT = 1;
  localparam int STAT_ERR_LSB = 4;
  localparam int STAT_VIEW_BIT = 8;
  localparam int STAT_RED_BIT = 9;
  localparam int STAT_GREEN_BIT = 10;

  // reset values of the drying profile
  localparam logic [7:0] START_TEMP_RST = 8'h14;
  localparam logic [7:0] HOLD_TEMP_RST = 8'h1E;
  localparam logic [7:0] RISE_RST = 8'h02;
  localparam logic [7:0] MAX_FLOW_RST = 8'h3C;
  localparam logic [7:0] RISE_TIME_RST = 8'h18;
  localparam logic [7:0] HOLD_DUR_RST = 8'h05;
  localparam logic [6:0] CIRC_RST = 7'h00;

  // supervision margins and persistence windows in minutes
  localparam logic [7:0] MAX_FLOW_MARGIN = 8'h05;
  localparam logic [13:0] ERR2_MIN = 14'h0005;
  localparam logic [13:0] ERR3_MIN = 14'h001E;
  localparam logic [13:0] ERR4_MIN = 14'h0078;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ERR_NONE = 3'h0,
    ERR_SENSOR = 3'h1,
    ERR_MAX_FLOW = 3'h2,
    ERR_ABOVE_HOLD = 3'h3,
    ERR_ABOVE_SET = 3'h4,
    ERR_BELOW_SET = 3'h5
  } sdr_err_t;

  // phases, gray coded along the drying path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CALC = 3'h1,
    ST_START = 3'h3,
    ST_RISE = 3'h2,
    ST_HOLD = 3'h6,
    ST_FALL = 3'h7,
    ST_ABORT = 3'h5
  } sdr_state_t;
endpackage
`default_nettype wire

// file: sdr_tick_if.sv
// second, minute and hour ticks shared inside the sequencer
`default_nettype none
interface sdr_tick_if;
  logic sec_tick;
  logic min_tick;
  logic hour_tick;
  modport src (output sec_tick, output min_tick, output hour_tick);
  modport dst (input sec_tick, input min_tick, input hour_tick);
endinterface
`default_nettype wire

// file: sdr_timebase.sv
// divider producing one-cycle second, minute and hour ticks
`default_nettype none
module sdr_timebase
  import sdr_pkg::*;
#(
  parameter longint CYC_PER_SEC_P = sdr_pkg::CYC_PER_SEC
)
(
  input wire logic aclk,
  input wire logic aresetn,
  sdr_tick_if.src tk
);
  localparam logic [31:0] CYC_LAST = 32'(CYC_PER_SEC_P - 1);
  logic [31:0] cyc, next_cyc;
  logic [5:0] sec, next_sec;
  logic [5:0] mins, next_mins;
  logic sec_end, min_end;

  // cascade of counters, ticks are decoded from the counter state
  always_comb
  begin
    sec_end = (cyc == CYC_LAST);
    min_end = sec_end && (sec == SEC_PER_MIN - 6'h01);
    next_cyc = sec_end ? 32'h0 : cyc + 32'h1;
    next_sec = sec;
    next_mins = mins;
    if (sec_end)
    begin
      next_sec = (sec == SEC_PER_MIN - 6'h01) ? 6'h00 : sec + 6'h01;
    end
    if (min_end)
    begin
      next_mins = (mins == MIN_PER_HOUR - 6'h01) ? 6'h00 : mins + 6'h01;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cyc <= 32'h0;
      sec <= 6'h00;
      mins <= 6'h00;
    end
    else
    begin
      cyc <= next_cyc;
      sec <= next_sec;
      mins <= next_mins;
    end
  end

  // second, minute and hour ticks for the green flash and the profile timing
  assign tk.sec_tick = sec_end;
  assign tk.min_tick = min_end;
  assign tk.hour_tick = min_end && (mins == MIN_PER_HOUR - 6'h01);
endmodule
`default_nettype wire

// file: sdr_monitor.sv
// flow temperature supervision with persistence windows
`default_nettype none
module sdr_monitor
  import sdr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  sdr_tick_if.dst tk,
  input wire logic active,
  input wire logic sensor_fault,
  input wire logic [7:0] flow_temp,
  input wire logic [7:0] set_temp,
  input wire logic [7:0] hold_temp,
  input wire logic [7:0] rise,
  input wire logic [7:0] max_flow,
  input wire logic [7:0] rise_time,
  output sdr_pkg::sdr_err_t fault_code
);
  logic [3:0] cond;
  logic [3:0] fire;
  logic [13:0] limit [4];
  logic [8:0] flow9;
  sdr_err_t next_code;

  // over/under conditions, widened so sums never wrap
  always_comb
  begin
    flow9 = {1'b0, flow_temp};
    cond[0] = flow9 > ({1'b0, max_flow} + {1'b0, MAX_FLOW_MARGIN});
    cond[1] = flow9 > ({1'b0, hold_temp} + {1'b0, rise});
    cond[2] = flow9 > ({1'b0, set_temp} + {1'b0, rise});
    cond[3] = (flow9 + {1'b0, rise}) < {1'b0, set_temp};
    limit[0] = ERR2_MIN;
    limit[1] = ERR3_MIN;
    limit[2] = ERR4_MIN;
    limit[3] = 14'({6'h00, rise_time} * 14'h003C);
  end

  // one persistence counter per condition, counting whole minutes
  for (genvar g = 0; g < 4; g++)
  begin : g_pers
    logic [13:0] cnt, next_cnt;
    always_comb
    begin
      next_cnt = cnt;
      if (!active || !cond[g])
      begin
        next_cnt = 14'h0000;
      end
      else if (tk.min_tick && cnt != limit[g])
      begin
        next_cnt = cnt + 14'h0001;
      end
    end
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        cnt <= 14'h0000;
      end
      else
      begin
        cnt <= next_cnt;
      end
    end
    // fires on the first minute beyond the window
    assign fire[g] = active && cond[g] && tk.min_tick && cnt == limit[g];
  end

  // first fault wins and stays until the run ends
  always_comb
  begin
    next_code = fault_code;
    if (!active)
    begin
      next_code = ERR_NONE;
    end
    else if (fault_code == ERR_NONE)
    begin
      if (sensor_fault)
        next_code = ERR_SENSOR;
      else if (fire[0])
        next_code = ERR_MAX_FLOW;
      else if (fire[1])
        next_code = ERR_ABOVE_HOLD;
      else if (fire[2])
        next_code = ERR_ABOVE_SET;
      else if (fire[3])
        next_code = ERR_BELOW_SET;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fault_code <= ERR_NONE;
    end
    else
    begin
      fault_code <= next_code;
    end
  end
endmodule
`default_nettype wire

// file: sdr_sequencer.sv
// screed drying sequencer top with AXI4-Lite register slave
// Notes on behaviour
// - start: run selected circuits one rise period at starting setpoint
// - then raise set temperature by rise value each period up to holding
// - after holding duration, lower in steps back to starting setpoint
// - cancel aborts the drying sequence immediately
// - start switches the panel to the drying status view
// - status view shows phase and remaining time as days and hours
// - panel indicator flashes green while drying
// - abort if set temperature not reached in time or constantly exceeded
// - fault abort: circuits off, error code posted, indicator steady red
// - error 1 when the flow sensor is defective
// - error 2: flow above maximum plus 5 K for over 5 minutes
// - error 3: flow above holding plus rise for over 30 minutes
// - error 4: flow above set plus rise for over 2 hours
// - error 5: flow below set minus rise for over one rise period
// - unselected circuits keep their own operating modes
// - on success drying circuits go to off mode, activation clears
// - with a memory card present, a log record is written per run; a cancelled run writes none
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`default_nettype none
module sdr_sequencer
  import sdr_pkg::*;
#(
  parameter longint CYC_PER_SEC_P = sdr_pkg::CYC_PER_SEC
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] flow_temp,
  input wire logic sensor_fault,
  input wire logic [6:0] hc_normal_on,
  input wire logic card_present,
  output logic [6:0] hc_on,
  output logic [6:0] hc_off_mode,
  output logic [7:0] hc_set_temp,
  output logic drying_view,
  output logic led_green,
  output logic led_red,
  output logic log_valid,
  output sdr_pkg::sdr_err_t log_code
);
  sdr_tick_if tk ();
  sdr_err_t fault_code;
  sdr_state_t state, next_state;
  logic [7:0] start_t, hold_t, rise, max_flow, rise_time, hold_days;
  logic [7:0] n_start_t, n_hold_t, n_rise, n_max_flow, n_rise_time;
  logic [7:0] n_hold_days;
  logic [6:0] circuits, n_circuits;
  logic aw_held, w_held, next_aw_held, next_w_held;
  logic [11:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_bvalid, next_rvalid, do_write, start_req, cancel_req;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [7:0] calc_t, next_calc, next_set, rem_d, next_rem_d;
  logic [4:0] rem_h, next_rem_h;
  logic [11:0] step_hrs, next_step, cur_len, hold_len;
  logic [6:0] next_off, next_hc_on;
  logic next_view, flash, next_flash, next_log, running;
  sdr_err_t err_code, next_err, next_log_code;
  logic [8:0] up_sum, dn_floor;
  logic [7:0] up_t, dn_t;
  logic step_last;

  sdr_timebase #(.CYC_PER_SEC_P(CYC_PER_SEC_P)) u_tb (
    .aclk(aclk),
    .aresetn(aresetn),
    .tk(tk.src)
  );

  sdr_monitor u_mon (
    .aclk(aclk),
    .aresetn(aresetn),
    .tk(tk.dst),
    .active(running),
    .sensor_fault(sensor_fault),
    .flow_temp(flow_temp),
    .set_temp(hc_set_temp),
    .hold_temp(hold_t),
    .rise(rise),
    .max_flow(max_flow),
    .rise_time(rise_time),
    .fault_code(fault_code)
  );

  // add hours to a days:hours pair, carrying at most two days into the days count
  function automatic logic [12:0] add_hours(input logic [7:0] d,
                                            input logic [4:0] h,
                                            input logic [5:0] add);
    logic [6:0] s;
    s = {2'h0, h} + {1'h0, add};
    if (s >= 7'h30)
      add_hours = {d + 8'h02, 5'(s - 7'h30)};
    else if (s >= 7'h18)
      add_hours = {d + 8'h01, 5'(s - 7'h18)};
    else
      add_hours = {d, s[4:0]};
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a[11:2] <= ADDR_SETT[11:2]);
  endfunction

  assign running = (state != ST_IDLE) && (state != ST_ABORT);
  // handshake readies, one write and one read in flight
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign start_req = do_write && aw_addr[11:2] == ADDR_CTRL[11:2] &&
                     w_strb[0] && w_data[CTRL_START_BIT] && !running;
  assign cancel_req = do_write && aw_addr[11:2] == ADDR_CTRL[11:2] &&
                      w_strb[0] && w_data[CTRL_CANCEL_BIT] && running;

  // write channel capture and profile configuration
  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    n_start_t = start_t;
    n_hold_t = hold_t;
    n_rise = rise;
    n_max_flow = max_flow;
    n_rise_time = rise_time;
    n_hold_days = hold_days;
    n_circuits = circuits;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      // profile is frozen while a run is in progress
      if (!running && aw_addr[11:2] == ADDR_TEMP[11:2])
      begin
        if (w_strb[0]) n_start_t = w_data[7:0];
        if (w_strb[1]) n_hold_t = w_data[15:8];
        if (w_strb[2]) n_rise = w_data[23:16];
        if (w_strb[3]) n_max_flow = w_data[31:24];
      end
      if (!running && aw_addr[11:2] == ADDR_TIME[11:2])
      begin
        if (w_strb[0]) n_rise_time = w_data[7:0];
        if (w_strb[1]) n_hold_days = w_data[15:8];
      end
      if (!running && aw_addr[11:2] == ADDR_CIRC[11:2] && w_strb[0])
      begin
        n_circuits = w_data[6:0];
      end
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      next_bvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      start_t <= START_TEMP_RST;
      hold_t <= HOLD_TEMP_RST;
      rise <= RISE_RST;
      max_flow <= MAX_FLOW_RST;
      rise_time <= RISE_TIME_RST;
      hold_days <= HOLD_DUR_RST;
      circuits <= CIRC_RST;
    end
    else
    begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      start_t <= n_start_t;
      hold_t <= n_hold_t;
      rise <= n_rise;
      max_flow <= n_max_flow;
      rise_time <= n_rise_time;
      hold_days <= n_hold_days;
      circuits <= n_circuits;
    end
  end

  // drying phases, countdown, status and log
  always_comb
  begin
    next_state = state;
    next_set = hc_set_temp;
    next_calc = calc_t;
    next_step = step_hrs;
    next_rem_d = rem_d;
    next_rem_h = rem_h;
    next_err = err_code;
    next_off = hc_off_mode;
    next_view = drying_view;
    next_log = 1'b0;
    next_log_code = log_code;
    next_flash = tk.sec_tick ? !flash : flash;
    hold_len = 12'({4'h0, hold_days} * {4'h0, HOUR_PER_DAY});
    cur_len = (state == ST_HOLD) ? hold_len : {4'h0, rise_time};
    step_last = tk.hour_tick && (step_hrs + 12'h001 >= cur_len);
    up_sum = {1'b0, hc_set_temp} + {1'b0, rise};
    up_t = (up_sum >= {1'b0, hold_t}) ? hold_t : up_sum[7:0];
    dn_floor = {1'b0, start_t} + {1'b0, rise};
    dn_t = ({1'b0, hc_set_temp} > dn_floor) ? hc_set_temp - rise : start_t;
    // countdown in days and hours while the profile runs
    if (running && state != ST_CALC && tk.hour_tick)
    begin
      if (rem_h != 5'h00)
      begin
        next_rem_h = rem_h - 5'h01;
      end
      else if (rem_d != 8'h00)
      begin
        next_rem_d = rem_d - 8'h01;
        next_rem_h = LAST_HOUR[4:0];
      end
    end
    if (running && state != ST_CALC)
    begin
      next_step = tk.hour_tick ? step_hrs + 12'h001 : step_hrs;
    end
    if (cancel_req)
    begin
      next_state = ST_IDLE;
      next_view = 1'b0;
    end
    else if (running && fault_code != ERR_NONE)
    begin
      next_state = ST_ABORT;
      next_err = fault_code;
      next_log = card_present;
      next_log_code = fault_code;
    end
    else
    begin
      unique case (state)
        ST_IDLE, ST_ABORT:
        begin
          if (start_req)
          begin
            next_state = ST_CALC;
            next_set = start_t;
            next_calc = start_t;
            next_step = 12'h000;
            next_err = ERR_NONE;
            next_off = 7'h00;
            next_view = 1'b1;
            {next_rem_d, next_rem_h} = add_hours(hold_days, 5'h00,
                                                 rise_time[5:0]);
          end
        end
        ST_CALC:
        begin
          // total time: one period, two per extra step, holding days
          if ({1'b0, calc_t} + {1'b0, rise} < {1'b0, hold_t})
          begin
            next_calc = calc_t + rise;
            {next_rem_d, next_rem_h} = add_hours(rem_d, rem_h,
                                                 {rise_time[4:0], 1'b0});
          end
          else
          begin
            next_state = ST_START;
          end
        end
        ST_START, ST_RISE:
        begin
          if (step_last)
          begin
            next_step = 12'h000;
            next_set = up_t;
            next_state = (up_t == hold_t) ? ST_HOLD : ST_RISE;
          end
        end
        ST_HOLD, ST_FALL:
        begin
          if (step_last)
          begin
            next_step = 12'h000;
            next_set = dn_t;
            next_state = ST_FALL;
            if (dn_t == start_t)
            begin
              next_state = ST_IDLE;
              next_off = circuits;
              next_view = 1'b0;
              next_log = card_present;
              next_log_code = ERR_NONE;
            end
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= ST_IDLE;
      hc_set_temp <= START_TEMP_RST;
      calc_t <= START_TEMP_RST;
      step_hrs <= 12'h000;
      rem_d <= 8'h00;
      rem_h <= 5'h00;
      err_code <= ERR_NONE;
      hc_off_mode <= 7'h00;
      drying_view <= 1'b0;
      flash <= 1'b0;
      log_valid <= 1'b0;
      log_code <= ERR_NONE;
    end
    else
    begin
      state <= next_state;
      hc_set_temp <= next_set;
      calc_t <= next_calc;
      step_hrs <= next_step;
      rem_d <= next_rem_d;
      rem_h <= next_rem_h;
      err_code <= next_err;
      hc_off_mode <= next_off;
      drying_view <= next_view;
      flash <= next_flash;
      log_valid <= next_log;
      log_code <= next_log_code;
    end
  end

  // per circuit drive: drying, switched off, or its own mode
  for (genvar i = 0; i < 7; i++)
  begin : g_hc
    assign next_hc_on[i] = !circuits[i] ? hc_normal_on[i] :
                           running ? 1'b1 :
                           (state == ST_ABORT || hc_off_mode[i]) ? 1'b0 :
                           hc_normal_on[i];
  end

  // registered circuit outputs; panel lamps follow the next phase
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hc_on <= 7'h00;
      led_green <= 1'b0;
      led_red <= 1'b0;
    end
    else
    begin
      hc_on <= next_hc_on;
      led_green <= next_flash && (next_state != ST_IDLE) &&
                   (next_state != ST_ABORT);
      led_red <= (next_state == ST_ABORT);
    end
  end

  // read channel: register mux captured on the address handshake
  always_comb
  begin
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      next_rdata = 32'h0000_0000;
      unique case (s_axi_araddr[11:2])
        ADDR_CTRL[11:2]: next_rdata = {30'h0, running, running};
        ADDR_TEMP[11:2]: next_rdata = {max_flow, rise, hold_t, start_t};
        ADDR_TIME[11:2]: next_rdata = {16'h0000, hold_days, rise_time};
        ADDR_CIRC[11:2]: next_rdata = {25'h0, circuits};
        ADDR_STAT[11:2]:
        begin
          next_rdata[2:0] = state;
          next_rdata[STAT_ERR_LSB +: 3] = err_code;
          next_rdata[STAT_VIEW_BIT] = drying_view;
          next_rdata[STAT_RED_BIT] = led_red;
          next_rdata[STAT_GREEN_BIT] = led_green;
        end
        ADDR_REMAIN[11:2]: next_rdata = {16'h0000, rem_d, 3'h0, rem_h};
        ADDR_SETT[11:2]: next_rdata = {16'h0000, flow_temp, hc_set_temp};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end
endmodule
`default_nettype wire

// file: sdr_sequencer_props.sv
// port assertions for the screed drying sequencer
`default_nettype none
module sdr_sequencer_props
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sensor_fault,
  input wire logic card_present,
  input wire logic drying_view,
  input wire logic led_green,
  input wire logic led_red
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // panel indicator and abort behaviour
  red_no_green_a: assert property (led_red |-> !led_green)
    else $error("red and green lit together");
  green_in_view_a: assert property (led_green |-> drying_view)
    else $error("green flash outside drying view");
  sensor_abort_a: assert property ($rose(sensor_fault)
    && drying_view |-> ##[1:4] led_red) else $error("no abort on sensor fault");
  // bus answers stand until taken, reads are answered; with a card the view is never left from red
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped");
  ar_answer_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read not answered");
  aw_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
  view_card_a: assert property (card_present && $fell(drying_view)
    |-> !$past(led_red)) else $error("view left from red");
  cover property ($rose(led_red));
  cover property ($rose(drying_view));
  cover property (s_axi_bvalid && !s_axi_bready);
endmodule
bind sdr_sequencer sdr_sequencer_props i_props (.aclk, .aresetn,
  .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .sensor_fault,
  .card_present, .drying_view, .led_green, .led_red);
`default_nettype wire

// file: sdr_plant.sv
// plant model: flow sensor and log card on the far side
`default_nettype none
module sdr_plant
  import sdr_pkg::*;
(
  input wire logic aclk,
  input wire logic [7:0] hc_set_temp,
  input wire logic [7:0] force_temp,
  input wire logic log_valid,
  input wire sdr_pkg::sdr_err_t log_code,
  output logic [7:0] flow_temp = 8'h14,
  output sdr_pkg::sdr_err_t last_code = ERR_NONE,
  output logic [3:0] log_cnt = 4'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  // flow follows the set value unless the bench imposes one; logs counted
  always @(posedge aclk)
  begin
    flow_temp <= (force_temp != 8'h00) ? force_temp : hc_set_temp;
    if (log_valid)
    begin
      log_cnt <= log_cnt + 4'h1;
      last_code <= log_code;
    end
  end
endmodule
`default_nettype wire

// file: sdr_sequencer_tb.sv
// self-checking bench for the screed drying sequencer
`default_nettype none
module sdr_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sdr_pkg::*;
  int bad_count = 0;
  int n_checks = 0;
  logic aclk = 1'h0, aresetn = 1'h0, sensor_fault = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, card_present = 1'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, drying_view, led_green, led_red, log_valid;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [6:0] hc_normal_on = 7'h42, hc_on, hc_off_mode;
  logic [7:0] flow_temp, hc_set_temp, force_temp = 8'h00;
  logic [7:0] tf [3] = '{8'h00, 8'h46, 8'h28};
  logic [3:0] log_cnt;
  sdr_err_t log_code, last_code;
  // one-cycle second keeps the hours short
  sdr_sequencer #(.CYC_PER_SEC_P(1)) i_dut (.*, .s_axi_wstrb(4'hF));
  sdr_plant i_plant (.*);
  // 100 MHz clock
  always #5 aclk = ~aclk;
  // compare and count
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // closing report
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one bus access: reads compare masked data, writes the response
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, exp, input logic [31:0] m = 32'hFFFFFFFF);
    logic ta, tw, va, dn;
    logic [1:0] rr;
    logic [31:0] got;
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_arvalid <= !w;
    n = 0;
    dn = 1'h0;
    while (!dn)
    begin
      @(negedge aclk);
      ta = w ? s_axi_awready : s_axi_arready;
      tw = s_axi_wready;
      va = w ? s_axi_bvalid : s_axi_rvalid;
      dn = va && (s_axi_bready || s_axi_rready);
      got = w ? {30'h0, s_axi_bresp} : s_axi_rdata;
      rr = s_axi_rresp;
      n++;
      if (n > 50)
      begin
        bad_count++;
        print_verdict();
      end
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (ta) s_axi_arvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      s_axi_bready <= w && va && !dn;
      s_axi_rready <= !w && va && !dn;
    end
    chk("bus", got & m, exp);
    if (!w)
      chk("rresp", {30'h0, rr},
        (a > ADDR_SETT) ? 32'(RESP_SLVERR) : 32'(RESP_OKAY));
  endtask
  // main sequence
  initial
  begin
    int n;
    logic rose;
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    xfer(0, ADDR_TEMP, 0, 32'h3C021E14);
    xfer(0, ADDR_TIME, 0, 32'h00000518);
    xfer(0, 12'h01C, 0, 0);
    xfer(1, 12'h020, 0, RESP_SLVERR);
    xfer(1, ADDR_CIRC, 5, RESP_OKAY);
    xfer(1, ADDR_CTRL, 1, RESP_OKAY);
    repeat (8) @(posedge aclk);
    xfer(0, ADDR_CTRL, 0, 3);
    xfer(0, ADDR_STAT, 0, 32'h103, 32'h3FF);
    xfer(0, ADDR_REMAIN, 0, 32'hE00);
    xfer(0, ADDR_SETT, 0, 32'h1414);
    @(negedge aclk);
    chk("hc_on", hc_on, 7'h47);
    xfer(1, ADDR_CTRL, 2, RESP_OKAY);
    xfer(0, ADDR_CTRL, 0, 0);
    @(negedge aclk);
    chk("cancel", {led_red, log_cnt, hc_on}, 12'h042);
    // faulted runs: sensor, above maximum, above holding
    for (int i = 0; i < 3; i++)
    begin
      xfer(1, ADDR_CTRL, 1, RESP_OKAY);
      repeat (8) @(posedge aclk);
      sensor_fault <= (i == 0);
      force_temp <= tf[i];
      n = 0;
      while (led_red !== 1'h1 && n < 20000)
      begin
        @(negedge aclk);
        n++;
      end
      if (n >= 20000)
      begin
        bad_count++;
        print_verdict();
      end
      repeat (3) @(negedge aclk);
      chk("abort", {hc_on, last_code, log_cnt},
        {7'h42, 3'(i + 1), 4'(i + 1)});
      xfer(0, ADDR_STAT, 0, 32'h200 | ((i + 1) << 4),
        32'h270);
      sensor_fault <= 1'h0;
    end
    // short profile to completion: one rise step, no holding days
    force_temp <= 8'h00;
    xfer(1, ADDR_TEMP, 32'h3C021614, RESP_OKAY);
    xfer(1, ADDR_TIME, 32'h00000001, RESP_OKAY);
    xfer(1, ADDR_CTRL, 1, RESP_OKAY);
    rose = 1'h0;
    n = 0;
    while (drying_view !== 1'h0 && n < 9000)
    begin
      @(negedge aclk);
      rose = rose | (hc_set_temp === 8'h16);
      n++;
    end
    if (n >= 9000)
    begin
      bad_count++;
      print_verdict();
    end
    repeat (3) @(negedge aclk);
    chk("done", {rose, hc_off_mode, hc_on, last_code, log_cnt},
      {1'h1, 7'h05, 7'h42, 3'h0, 4'h4});
    chk("end set", hc_set_temp, 8'h14);
    xfer(0, ADDR_STAT, 0, 0, 32'h7FF);
    print_verdict();
  end
endmodule
`default_nettype wire
